/* pkg/lsu_cfg.svh */
/*
 * Offsets, opcode field codes, flag positions and counts of the logical
 * shift unit. Assumes it is included by its bare name; a guard makes repeat inclusion harmless.
 */
`ifndef LSU_CFG_SVH
`define LSU_CFG_SVH

// ***************************************************
// register map (byte addresses)
// ***************************************************
`define LSU_OFS_OPCODE 8'h00
`define LSU_OFS_MEMWORD 8'h04
`define LSU_OFS_CCR 8'h08
`define LSU_OFS_STATUS 8'h0c
`define LSU_DREG_WIN 3'h1

// ***************************************************
// flag positions and reset values
// ***************************************************
`define LSU_CCR_X 4
`define LSU_CCR_N 3
`define LSU_CCR_Z 2
`define LSU_CCR_V 1
`define LSU_CCR_C 0
`define LSU_CCR_RST 5'h00
`define LSU_ST_BUSY 0
`define LSU_ST_ILLEGAL 1

// ***************************************************
// opcode decode codes
// ***************************************************
`define LSU_DIR_BIT 8
`define LSU_SRC_BIT 5
`define LSU_REG_TOP 4'he
`define LSU_REG_MID 2'h1
`define LSU_MEM_TOP 7'h71
`define LSU_MEM_SIZE 2'h3
`define LSU_SZ_BYTE 2'h0
`define LSU_SZ_WORD 2'h1
`define LSU_SZ_LONG 2'h2
`define LSU_EA_FIRST 3'h2
`define LSU_EA_LAST 3'h6
`define LSU_EA_ABS 3'h7
`define LSU_EA_ABSL 3'h1

// ***************************************************
// counts
// ***************************************************
`define LSU_IMM_ZERO_CNT 6'h08
`define LSU_MEM_CNT 6'h01
`define LSU_RD_LAST 2'h2

`endif

/* pkg/lsu_pkg.sv */
/*
 * Types of the logical shift unit: sequencer states and the packed
 * state record. Assumes nothing of its surroundings.
 */
`default_nettype none

package lsu_pkg;

   typedef enum logic [1:0] {
      LSU_IDLE,
      LSU_RDCNT,
      LSU_RDDST,
      LSU_EXEC
   } lsu_fsm_t;

   typedef struct packed {
      lsu_fsm_t fsm;
      logic [15:0] opcode;
      logic [15:0] memWord;
      logic [4:0] ccr;
      logic illegal;
      logic [5:0] count;
      logic [1:0] rdStage;
      logic [31:0] rdData;
      logic [7:0] doneCnt;
   } lsu_state_t;

endpackage

`default_nettype wire

/* core/lsu_dreg_file.sv */
/*
 * Data register file of the shift unit: one registered read port and
 * one write port. Assumes a single clock and synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none

module lsu_dreg_file #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [AW-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] cells;
      logic [WIDTH-1:0] q;
   } lsu_rf_t;

   lsu_rf_t r;
   lsu_rf_t next_r;

   // read is registered so the data leave from a flop
   always_comb begin
      next_r = r;
      next_r.q = r.cells[rdAddr];
      for (int i = 0; i < DEPTH; i++) begin
         if (wrEn && (wrAddr == i[AW-1:0])) begin
            next_r.cells[i] = wrData;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rdData = r.q;

endmodule

`default_nettype wire

/* core/lsu_logical_shift_unit.sv */
/*
 * Logical shift unit: decodes shift opcodes, runs register and memory
 * form shifts and updates the condition flags, reached over Avalon-MM.
 * Assumes one clock, synchronous reset and a well-behaved bus master.
 */
// Notes on behaviour
// RL1: carry takes the final bit shifted out
// RL2: immediate count 1-7 as given, zero means eight
// RL3: register count is register value modulo 64
// RL4: register destinations shift byte, word or long
// RL5: memory operand shifts one place, always word
// RL6: left shift: top bit out, zeros fill low
// RL7: right shift: low bit out, zeros fill high
// RL8: extend from last bit out, kept on zero count
// RL9: carry cleared on zero count, else last bit
// RL10: negative and zero from result, overflow cleared
// RL11: register form decode and its register fields
// RL12: bit five picks immediate or register count
// RL13: bit eight picks direction, one means left
// RL14: size field: byte, word, long codes
// RL15: write back only bits inside operand width
// RL16: memory form decode with direction and address
// RL17: only memory alterable address modes are accepted
// RL18: oversize register count gives zero result
`timescale 1ns/1ps
`default_nettype none
`include "lsu_cfg.svh"

module lsu_logical_shift_unit (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [4:0] ccrFlags,
   output logic illegalOp
);

   // ***************************************************
   // decode helpers
   // ***************************************************

   function automatic logic isRegForm(input logic [15:0] op);
      isRegForm = (op[15:12] == `LSU_REG_TOP) && // [RL11]
         (op[4:3] == `LSU_REG_MID) && (op[7:6] != `LSU_MEM_SIZE);
   endfunction

   function automatic logic isMemForm(input logic [15:0] op);
      isMemForm = (op[15:9] == `LSU_MEM_TOP) && // [RL16]
         (op[7:6] == `LSU_MEM_SIZE);
   endfunction

   // memory alterable modes only [RL17]
   function automatic logic eaLegal(input logic [5:0] ea);
      eaLegal = ((ea[5:3] >= `LSU_EA_FIRST) && (ea[5:3] <= `LSU_EA_LAST))
         || ((ea[5:3] == `LSU_EA_ABS) && (ea[2:0] <= `LSU_EA_ABSL));
   endfunction

   function automatic logic [5:0] widthOf(input logic [1:0] sz);
      unique case (sz) // [RL14]
         `LSU_SZ_BYTE: widthOf = 6'h08;
         `LSU_SZ_WORD: widthOf = 6'h10;
         default: widthOf = 6'h20;
      endcase
   endfunction

   function automatic logic [31:0] maskOf(input logic [1:0] sz);
      unique case (sz)
         `LSU_SZ_BYTE: maskOf = 32'h0000_00ff;
         `LSU_SZ_WORD: maskOf = 32'h0000_ffff;
         default: maskOf = 32'hffff_ffff;
      endcase
   endfunction

   function automatic logic [31:0] mergeBe(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] be);
      mergeBe = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            mergeBe[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   // carry in bit 32, result below; counts past the width drop all bits
   function automatic logic [32:0] shiftOp(input logic [31:0] v,
         input logic [1:0] sz, input logic [5:0] cnt, input logic left);
      logic [31:0] vm;
      logic [31:0] res;
      logic [5:0] w;
      logic [5:0] idx;
      logic c;
      vm = v & maskOf(sz);
      w = widthOf(sz);
      if (left) begin
         res = (vm << cnt) & maskOf(sz); // [RL6]
         idx = w - cnt;
      end else begin
         res = vm >> cnt; // [RL7]
         idx = cnt - 6'h01;
      end
      c = 1'b0;
      if ((cnt != 6'h00) && (cnt <= w)) begin
         c = vm[idx[4:0]]; // [RL1] [RL18]
      end
      shiftOp = {c, res};
   endfunction

   // ***************************************************
   // state and register file
   // ***************************************************

   lsu_pkg::lsu_state_t s;
   lsu_pkg::lsu_state_t next_s;
   logic [2:0] memRdAddr;
   logic [31:0] memQ;
   logic memWrEn;
   logic [2:0] memWrAddr;
   logic [31:0] memWrData;
   logic [15:0] newOp;
   logic [31:0] operand;
   logic [1:0] opSize;
   logic [32:0] shifted;
   logic [5:0] opWidth;
   logic memForm;
   logic busy;

   lsu_dreg_file #(
      .WIDTH(32),
      .DEPTH(8),
      .AW(3)
   ) u_dregs (
      .sys_clk(sys_clk),
      .reset(reset),
      .rdAddr(memRdAddr),
      .rdData(memQ),
      .wrEn(memWrEn),
      .wrAddr(memWrAddr),
      .wrData(memWrData)
   );

   assign busy = (s.fsm != lsu_pkg::LSU_IDLE);
   assign memForm = isMemForm(s.opcode);
   assign opSize = memForm ? `LSU_SZ_WORD : s.opcode[7:6]; // [RL4] [RL5]
   assign opWidth = widthOf(opSize);
   assign operand = memForm ? {16'h0000, s.memWord} : memQ;
   assign shifted = shiftOp(operand, opSize, s.count,
      s.opcode[`LSU_DIR_BIT]); // [RL13]
   assign newOp = 16'(mergeBe({16'h0000, s.opcode}, avs_writedata,
      avs_byteenable));

   // ***************************************************
   // bus slave and sequencer
   // ***************************************************

   // reads take three edges so that read data always leave a flop
   always_comb begin
      next_s = s;
      memRdAddr = avs_address[4:2];
      memWrEn = 1'b0;
      memWrAddr = avs_address[4:2];
      memWrData = mergeBe(memQ, avs_writedata, avs_byteenable);
      unique case (s.fsm)
         lsu_pkg::LSU_IDLE: begin
            if (avs_read) begin
               if (s.rdStage == `LSU_RD_LAST) begin
                  next_s.rdStage = 2'h0;
               end else begin
                  next_s.rdStage = s.rdStage + 2'h1;
               end
               if (s.rdStage == 2'h1) begin
                  if (avs_address[7:5] == `LSU_DREG_WIN) begin
                     next_s.rdData = memQ;
                  end else begin
                     unique case (avs_address)
                        `LSU_OFS_OPCODE: next_s.rdData = {16'h0, s.opcode};
                        `LSU_OFS_MEMWORD: next_s.rdData = {16'h0, s.memWord};
                        `LSU_OFS_CCR: next_s.rdData = {27'h0, s.ccr};
                        `LSU_OFS_STATUS: next_s.rdData =
                           {16'h0, s.doneCnt, 6'h00, s.illegal, 1'b0};
                        default: next_s.rdData = 32'h0;
                     endcase
                  end
               end
            end
            if (avs_write) begin
               if (avs_address[7:5] == `LSU_DREG_WIN) begin
                  // read-modify-write would cost a cycle; lanes are
                  // merged onto the registered read, which holds the word addressed a cycle earlier
                  memWrEn = 1'b1;
                  memWrData = mergeBe(memQ, avs_writedata, avs_byteenable);
               end else begin
                  unique case (avs_address)
                     `LSU_OFS_OPCODE: begin
                        next_s.opcode = newOp;
                        if (isRegForm(newOp)) begin
                           next_s.fsm = lsu_pkg::LSU_RDCNT; // [RL11]
                        end else if (isMemForm(newOp) &&
                              eaLegal(newOp[5:0])) begin
                           next_s.count = `LSU_MEM_CNT; // [RL5]
                           next_s.fsm = lsu_pkg::LSU_EXEC;
                        end else begin
                           next_s.illegal = 1'b1; // [RL17]
                        end
                     end
                     `LSU_OFS_MEMWORD: begin
                        next_s.memWord = 16'(mergeBe({16'h0, s.memWord},
                           avs_writedata, avs_byteenable));
                     end
                     `LSU_OFS_CCR: begin
                        next_s.ccr = 5'(mergeBe({27'h0, s.ccr},
                           avs_writedata, avs_byteenable));
                     end
                     `LSU_OFS_STATUS: begin
                        // write one clears; no set can land here
                        if (avs_byteenable[0] &&
                              avs_writedata[`LSU_ST_ILLEGAL]) begin
                           next_s.illegal = 1'b0;
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
         end
         lsu_pkg::LSU_RDCNT: begin
            memRdAddr = s.opcode[11:9];
            next_s.fsm = lsu_pkg::LSU_RDDST;
         end
         lsu_pkg::LSU_RDDST: begin
            memRdAddr = s.opcode[2:0];
            if (s.opcode[`LSU_SRC_BIT]) begin
               next_s.count = memQ[5:0]; // [RL12] [RL3]
            end else if (s.opcode[11:9] == 3'h0) begin
               next_s.count = `LSU_IMM_ZERO_CNT; // [RL2]
            end else begin
               next_s.count = {3'h0, s.opcode[11:9]}; // [RL2]
            end
            next_s.fsm = lsu_pkg::LSU_EXEC;
         end
         lsu_pkg::LSU_EXEC: begin
            memRdAddr = s.opcode[2:0];
            if (s.count != 6'h00) begin
               next_s.ccr[`LSU_CCR_X] = shifted[32]; // [RL8]
            end
            next_s.ccr[`LSU_CCR_C] = (s.count != 6'h00) & shifted[32]; // [RL9]
            next_s.ccr[`LSU_CCR_N] = shifted[opWidth - 6'h01]; // [RL10]
            next_s.ccr[`LSU_CCR_Z] = (shifted[31:0] == 32'h0); // [RL10]
            next_s.ccr[`LSU_CCR_V] = 1'b0; // [RL10]
            if (memForm) begin
               next_s.memWord = shifted[15:0]; // [RL5]
            end else begin
               memWrEn = 1'b1;
               memWrAddr = s.opcode[2:0];
               memWrData = (memQ & ~maskOf(opSize)) | shifted[31:0]; // [RL15]
            end
            next_s.doneCnt = s.doneCnt + 8'h01;
            next_s.fsm = lsu_pkg::LSU_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************

   // the bus waits out a running shift rather than queue behind it
   assign avs_waitrequest = busy || (avs_read && (s.rdStage != `LSU_RD_LAST));
   assign avs_readdata = s.rdData;
   assign ccrFlags = s.ccr;
   assign illegalOp = s.illegal;

   // ***************************************************
   // checks
   // ***************************************************

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence seqOpWrite;
      !busy && avs_write && (avs_address == `LSU_OFS_OPCODE) &&
         (avs_byteenable[1:0] == 2'h3);
   endsequence

   sequence seqRegStart;
      seqOpWrite ##0 isRegForm(avs_writedata[15:0]);
   endsequence

   sequence seqMemStart;
      seqOpWrite ##0 isMemForm(avs_writedata[15:0]);
   endsequence

   sequence seqRegRun;
      (s.fsm == lsu_pkg::LSU_RDCNT) ##1 (s.fsm == lsu_pkg::LSU_RDDST)
         ##1 (s.fsm == lsu_pkg::LSU_EXEC) ##1 (s.fsm == lsu_pkg::LSU_IDLE);
   endsequence

   chk_reg_sequence: assert property ( // [RL11]
      seqRegStart |=> seqRegRun)
      else $error("register form did not run its four steps");

   chk_imm_count: assert property ( // [RL2]
      (s.fsm == lsu_pkg::LSU_RDDST) && !s.opcode[`LSU_SRC_BIT] |=>
      s.count == (($past(s.opcode[11:9]) == 3'h0) ? 6'h08 :
         {3'h0, $past(s.opcode[11:9])}))
      else $error("immediate count decoded wrongly");

   chk_reg_count: assert property ( // [RL3]
      (s.fsm == lsu_pkg::LSU_RDDST) && s.opcode[`LSU_SRC_BIT] |=>
      s.count == $past(memQ[5:0]))
      else $error("register count not taken modulo 64");

   chk_mem_single: assert property ( // [RL5]
      seqMemStart ##0 eaLegal(avs_writedata[5:0]) |=>
      (s.fsm == lsu_pkg::LSU_EXEC) && (s.count == 6'h01) ##1 !busy)
      else $error("memory shift not one place");

   chk_bad_ea: assert property ( // [RL17]
      seqMemStart ##0 !eaLegal(avs_writedata[5:0]) |=> s.illegal && !busy)
      else $error("illegal address mode accepted");

   chk_zero_count: assert property ( // [RL8] [RL9]
      (s.fsm == lsu_pkg::LSU_EXEC) && (s.count == 6'h00) |=>
      !s.ccr[`LSU_CCR_C] && (s.ccr[`LSU_CCR_X] == $past(s.ccr[`LSU_CCR_X])))
      else $error("zero count flags wrong");

   chk_ovf_clear: assert property ( // [RL10]
      (s.fsm == lsu_pkg::LSU_EXEC) |=> !s.ccr[`LSU_CCR_V] &&
      (s.ccr[`LSU_CCR_Z] == ($past(shifted[31:0]) == 32'h0)))
      else $error("overflow or zero flag wrong");

   chk_left_fill: assert property ( // [RL6]
      memWrEn && (s.fsm == lsu_pkg::LSU_EXEC) && s.opcode[`LSU_DIR_BIT] &&
      (s.count != 6'h00) |-> !memWrData[0])
      else $error("left shift did not fill zero");

   chk_right_sign: assert property ( // [RL7]
      (s.fsm == lsu_pkg::LSU_EXEC) && !s.opcode[`LSU_DIR_BIT] &&
      (s.count != 6'h00) |=> !s.ccr[`LSU_CCR_N])
      else $error("right shift left a sign bit");

   chk_width_keep: assert property ( // [RL15]
      memWrEn && (s.fsm == lsu_pkg::LSU_EXEC) &&
      (opSize == `LSU_SZ_BYTE) |-> memWrData[31:8] == memQ[31:8])
      else $error("bits above byte width changed");

   chk_carry_last: assert property ( // [RL1]
      (s.fsm == lsu_pkg::LSU_EXEC) && !memForm && s.opcode[`LSU_DIR_BIT] &&
      (opSize == `LSU_SZ_BYTE) && (s.count == 6'h01) |=>
      s.ccr[`LSU_CCR_C] == $past(memQ[7]))
      else $error("carry is not last bit out");

endmodule

`default_nettype wire

/* tb/lsu_seq_model.sv */
/*
 * Bus-master model of the sequencer side of the shift unit: it issues
 * register reads and writes. Assumes one clock and an Avalon slave
 * that lowers waitrequest to complete each access.
 */
`timescale 1ns/1ps
`default_nettype none

module lsu_seq_model (
   input wire logic sys_clk,
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   output logic hung
);
   // ***************************************************
   // idle values
   // ***************************************************
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hf;
      hung = 1'b0;
   end

   // ***************************************************
   // one access, held until waitrequest is seen low
   // ***************************************************
   // waitrequest and read data are looked at on rising edges only, so
   // the request stands unchanged at the edge that completes it
   task automatic access(input logic rd, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] q);
      int n;
      begin
         n = 0;
         q = 32'h00000000;
         avs_address <= a;
         avs_writedata <= d;
         avs_read <= rd;
         avs_write <= !rd;
         @(posedge sys_clk);
         while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge sys_clk);
            n++;
         end
         if (n >= 50) begin
            hung <= 1'b1;
         end
         // the completing edge: take read data here, release after it
         q = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         // one idle edge so a new request is never set in this step
         @(posedge sys_clk);
      end
   endtask
endmodule

`default_nettype wire

/* tb/lsu_logical_shift_unit_bench.sv */
/*
 * Self-checking bench of the logical shift unit: shifts, flags, decode
 * and refusals seen through the register bus. Assumes the sequencer
 * model beside it for every bus access.
 */
`timescale 1ns/1ps
`default_nettype none

module lsu_logical_shift_unit_bench;
   logic sys_clk;
   logic reset;
   logic [7:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [4:0] ccrFlags;
   logic illegalOp;
   logic hung;
   logic [31:0] rdv;
   int err_count = 0;
   int samples_checked = 0;

   // ***************************************************
   // clock, instances
   // ***************************************************
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;

   lsu_logical_shift_unit lsu_logical_shift_unit_inst (
      .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ccrFlags(ccrFlags), .illegalOp(illegalOp));

   lsu_seq_model lsu_seq_model_inst (
      .sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .hung(hung));

   // ***************************************************
   // shared helpers
   // ***************************************************
   task automatic report_and_stop();
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // a hung bus access ends the run at once
   always @(posedge sys_clk) begin
      if (hung === 1'b1) begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      lsu_seq_model_inst.access(1'b0, a, d, rdv);
   endtask

   task automatic rd(input logic [7:0] a);
      lsu_seq_model_inst.access(1'b1, a, 32'h00000000, rdv);
   endtask

   // preset flags and operand, run one opcode, judge operand and flags
   task automatic shift_case(input logic [15:0] opc, input logic [7:0] a,
                             input logic [31:0] init, input logic [4:0] pre,
                             input logic [31:0] expRes,
                             input logic [4:0] expCcr);
      wr(8'h08, {27'h0, pre});
      wr(a, init);
      wr(8'h00, {16'h0, opc});
      rd(a);
      check(rdv, expRes);
      rd(8'h08);
      check(rdv, {27'h0, expCcr});
      check({27'h0, ccrFlags}, {27'h0, expCcr});
   endtask

   // ***************************************************
   // scenarios
   // ***************************************************
   // reset values and an unmapped read
   task automatic sc_reset();
      check({27'h0, ccrFlags}, 32'h0);
      rd(8'h28);
      check(rdv, 32'h0);
      rd(8'h10);
      check(rdv, 32'h0);
   endtask

   // every immediate count on a long right shift of all ones
   task automatic sc_imm_counts();
      logic [2:0] f;
      for (int n = 1; n <= 8; n++) begin
         f = 3'(n % 8);
         shift_case(16'he08d | {4'h0, f, 9'h0}, 8'h34, 32'hffffffff,
                    5'h00, 32'hffffffff >> n, 5'h11);
      end
   endtask

   // each size code; bits above the width must survive
   task automatic sc_sizes();
      shift_case(16'he30e, 8'h38, 32'h80808080, 5'h00, 32'h80808000,
                 5'h15);
      shift_case(16'he34e, 8'h38, 32'h80808080, 5'h00, 32'h80800100,
                 5'h11);
      shift_case(16'he38e, 8'h38, 32'h80808080, 5'h0a, 32'h01010100,
                 5'h11);
   endtask

   // register count taken modulo 64, zero and oversize counts
   task automatic sc_reg_counts();
      wr(8'h28, 32'h00000041);
      shift_case(16'he5ab, 8'h2c, 32'hc0000001, 5'h00, 32'h80000002,
                 5'h19);
      wr(8'h28, 32'h00000040);
      shift_case(16'he4ab, 8'h2c, 32'h80000000, 5'h13, 32'h80000000,
                 5'h18);
      wr(8'h28, 32'h00000009);
      shift_case(16'he42c, 8'h30, 32'h000000ff, 5'h1f, 32'h00000000,
                 5'h04);
      shift_case(16'he10c, 8'h30, 32'h55555501, 5'h00, 32'h55555500,
                 5'h15);
   endtask

   // memory form in both directions, and left shifts over every accepted address mode
   task automatic sc_memory();
      logic [5:0] ea [7] = '{6'h10, 6'h18, 6'h20, 6'h28, 6'h30, 6'h38,
                             6'h39};
      shift_case(16'he3d0, 8'h04, 32'h00008001, 5'h00, 32'h00000002,
                 5'h11);
      shift_case(16'he2d8, 8'h04, 32'h00000001, 5'h00, 32'h00000000,
                 5'h15);
      foreach (ea[i]) begin
         shift_case(16'he3c0 | {10'h0, ea[i]}, 8'h04, 32'h00004000,
                    5'h00, 32'h00008000, 5'h08);
      end
   endtask

   // refused address modes and size code: no shift, no flag change
   task automatic sc_illegal();
      logic [15:0] bad [6] = '{16'he3c0, 16'he3c8, 16'he3fc, 16'he3fa,
                               16'he3fb, 16'he0c8};
      foreach (bad[i]) begin
         wr(8'h0c, 32'h00000002);
         check({31'h0, illegalOp}, 32'h0);
         wr(8'h08, 32'h0000000a);
         wr(8'h04, 32'h00001234);
         wr(8'h00, {16'h0, bad[i]});
         rd(8'h04);
         check(rdv, 32'h00001234);
         check({31'h0, illegalOp}, 32'h1);
         check({27'h0, ccrFlags}, 32'h0000000a);
      end
   endtask

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      reset = 1'b1;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      sc_reset();
      sc_imm_counts();
      sc_sizes();
      sc_reg_counts();
      sc_memory();
      sc_illegal();
      report_and_stop();
   end
endmodule

`default_nettype wire
